// File: hw/fmi_seq.sv
// design: command sequencer for multi-io programming, security registers and deep power-down
`timescale 1ns/10ps
// Function
// - Code a2 takes two data bits per clock on io1 and io0.
// - Dual program writes one to 256 bytes into erased locations.
// - Dual program: code, three address bytes on io0, data bytes on two lines.
// - Dual and quad programs are refused on pages under the block protect bits.
// - Code 32 accepted only with write enable latch and quad enable both set.
// - Quad program: code and address on io0, data four bits per clock.
// - Three separate 256-byte security registers, erased and programmed one at a time.
// - Code 44 takes a 24-bit address and needs the write enable latch.
// - Erase runs only if select rises right after the address; lasts sector erase time.
// - Busy flag reads one during erase; busy flag and latch clear at the end.
// - A set lock bit makes erase and program of its register ignored.
// - Address top byte zero, bits 15-12 pick register 1 to 3, bits 11-8 zero.
// - Code 42 takes a 24-bit address and one to 256 bytes on io0.
// - Code 48: address, eight dummy clocks, then data msb first on falling edges.
// - Read byte address advances each byte and wraps ff to 00 in the register.
// - A security read while busy is ignored and leaves the cycle alone.
// - Code b9 runs only if select rises after eight bits; entry after delay.
// - In deep power-down every command but ab is ignored; ab ends it.
// - Power-down request during a busy cycle is rejected with no effect.
// - Device starts in standby, never in deep power-down.
// - Programs run only if select rises right after a whole data byte.
// - Data past the page end wraps to the start of the same page.
// - Beyond 256 bytes, the last 256 bytes are the ones programmed.
module fmi_seq
	import fmi_pkg::*;
#(
	parameter int SECTOR_ERASE_CYCLES = SECTOR_ERASE_CYC,
	parameter int PAGE_PROG_CYCLES    = PAGE_PROG_CYC
) (
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic       sclk,
	input  wire logic       csN,
	input  wire logic [3:0] ioIn,
	output logic      [3:0] ioOut,
	output logic      [3:0] ioOeN,
	input  wire logic       writeEnableLatch,
	input  wire logic       quadEnableBit,
	input  wire logic [4:0] blockProtectBits,
	input  wire logic [2:0] otpLockBits,
	output logic            writeInProgress,
	output logic            welClear,
	output logic            sleeping,
	output fmi_wr_t         progWr
);
	localparam int SLEEP_LAT = SLEEP_ENTRY_CYC;

	// link side (serial clock)
	logic [5:0]  hdr_ff;
	logic [2:0]  grp_ff;
	logic [7:0]  asm_ff;
	logic [7:0]  dataByte_ff;
	logic        dataTgl_ff;
	logic        frameTgl_ff;
	logic        reqTgl_ff;
	logic [7:0]  rdByte_ff;
	fmi_link_t   link_ff;
	logic        wipS1_ff, wipS2_ff, slpS1_ff, slpS2_ff;
	logic        soBit_ff, soOeN_ff;
	logic [7:0]  soSh_ff;
	logic [2:0]  grpLast;
	logic [7:0]  nxt_asm;
	logic        rdGo;

	// core side (clk)
	logic        csS1_ff, csS2_ff, csPrev_ff;
	logic        frS1_ff, frS2_ff, frSeen_ff;
	logic        dtS1_ff, dtS2_ff, dtPrev_ff;
	logic        rqS1_ff, rqS2_ff, rqPrev_ff;
	fmi_state_t  state_ff;
	fmi_op_t     op_ff;
	logic [8:0]  idx_ff;
	logic [31:0] tmr_ff;
	logic [1:0]  sel_ff;
	logic [15:0] page_ff;
	logic        wip_ff, welClr_ff, sleeping_ff;
	logic [7:0]  rdData_ff;
	logic [7:0]  wrPtr_ff;
	logic        first_ff;
	logic [PAGE_BYTES-1:0] vld_ff;
	logic [7:0]  pageBuf [PAGE_BYTES];
	logic [7:0]  secMem [SEC_REGS*PAGE_BYTES];
	fmi_wr_t     progWr_ff;
	logic        frameEnd, frameStart, frameNew, byteEvt, reqEvt;
	logic [1:0]  secSel;
	logic        secOk, secLocked, pageProt;
	logic        goSleep, goWake, goErase, goSecProg, goMain, decide;
	logic [7:0]  bufIdx;

	function automatic logic [1:0] sec_select(input logic [23:0] a);
		if (a[23:16] == SEC_HI_VAL && a[11:8] == SEC_MID_VAL &&
				a[15:12] != 4'h0 && a[15:12] <= SEC_SEL_MAX) begin
			return a[13:12];
		end
		return 2'h0;
	endfunction

	// bp[3:0] = n in 1..5 protects 2^(n-1) of the 16 blocks, above 5 all 16, top down, or bottom up with bp[4]
	function automatic logic is_protected(input logic [23:0] a, input logic [4:0] bp);
		logic [4:0] cnt;
		cnt = 5'h00;
		if (bp[3:0] != 4'h0) begin
			cnt = (bp[3:0] > 4'h5) ? 5'h10 : 5'(5'h01 << (bp[3:0] - 4'h1));
		end
		if (bp[4]) begin
			return {1'b0, a[19:16]} < cnt;
		end
		return {1'b0, a[19:16]} >= 5'(5'h10 - cnt);
	endfunction

	always_comb begin
		case (link_ff.cmd)
			CMD_DUAL_PROG: grpLast = 3'h3;
			CMD_QUAD_PROG: grpLast = 3'h1;
			default:       grpLast = 3'h7;
		endcase
	end

	always_comb begin
		case (link_ff.cmd)
			CMD_DUAL_PROG: nxt_asm = {asm_ff[5:0], ioIn[1], ioIn[0]};
			CMD_QUAD_PROG: nxt_asm = {asm_ff[3:0], ioIn[3:0]};
			default:       nxt_asm = {asm_ff[6:0], ioIn[0]};
		endcase
	end

	// frame counters die with chip select, so nothing outlives the frame here
	always_ff @(posedge sclk or posedge csN) begin
		if (csN) begin
			hdr_ff <= 6'h00;
			grp_ff <= 3'h0;
		end else begin
			if (hdr_ff != DUMMY_END) begin
				hdr_ff <= hdr_ff + 6'h01;
			end
			if (hdr_ff >= ADDR_END) begin
				grp_ff <= (grp_ff == grpLast) ? 3'h0 : grp_ff + 3'h1;
			end
		end
	end

	// frame summary must survive chip select rising, so it resets only with nrst
	always_ff @(posedge sclk or negedge nrst) begin
		if (!nrst) begin
			link_ff     <= '0;
			asm_ff      <= 8'h00;
			dataByte_ff <= 8'h00;
			dataTgl_ff  <= 1'b0;
			frameTgl_ff <= 1'b0;
			reqTgl_ff   <= 1'b0;
			rdByte_ff   <= 8'h00;
		end else begin
			if (hdr_ff == 6'h00) begin
				frameTgl_ff <= ~frameTgl_ff;
			end
			link_ff.atCmdEnd  <= (hdr_ff == CMD_END - 6'h01);
			link_ff.atAddrEnd <= (hdr_ff == ADDR_END - 6'h01);
			link_ff.atByteEnd <= (hdr_ff >= ADDR_END) && (grp_ff == grpLast);
			if (hdr_ff < CMD_END) begin
				link_ff.cmd <= {link_ff.cmd[6:0], ioIn[0]};
			end else if (hdr_ff < ADDR_END) begin
				link_ff.addr <= {link_ff.addr[22:0], ioIn[0]};
			end else begin
				asm_ff <= nxt_asm;
				if (grp_ff == grpLast) begin
					dataByte_ff <= nxt_asm;
					dataTgl_ff  <= ~dataTgl_ff;
				end
			end
			if (hdr_ff == ADDR_END - 6'h01) begin
				rdByte_ff <= {link_ff.addr[6:0], ioIn[0]};
				reqTgl_ff <= ~reqTgl_ff;
			end else if (hdr_ff == DUMMY_END && grp_ff == 3'h0) begin
				rdByte_ff <= rdByte_ff + 8'h01;
				reqTgl_ff <= ~reqTgl_ff;
			end
		end
	end

	always_ff @(posedge sclk or negedge nrst) begin
		if (!nrst) begin
			wipS1_ff <= 1'b0;
			wipS2_ff <= 1'b0;
			slpS1_ff <= 1'b0;
			slpS2_ff <= 1'b0;
		end else begin
			wipS1_ff <= wip_ff;
			wipS2_ff <= wipS1_ff;
			slpS1_ff <= sleeping_ff;
			slpS2_ff <= slpS1_ff;
		end
	end

	assign rdGo = (link_ff.cmd == CMD_SEC_READ) && !wipS2_ff && !slpS2_ff &&
		(sec_select(link_ff.addr) != 2'h0);

	// rdData_ff was fetched at least seven sclk rises earlier and is stable when loaded here
	always_ff @(negedge sclk or posedge csN) begin
		if (csN) begin
			soBit_ff <= 1'b0;
			soOeN_ff <= 1'b1;
			soSh_ff  <= 8'h00;
		end else if (hdr_ff == DUMMY_END && grp_ff == 3'h0) begin
			soBit_ff <= rdData_ff[7];
			soSh_ff  <= {rdData_ff[6:0], 1'b0};
			soOeN_ff <= ~rdGo;
		end else begin
			soBit_ff <= soSh_ff[7];
			soSh_ff  <= {soSh_ff[6:0], 1'b0};
		end
	end

	assign ioOut = {2'b00, soBit_ff, 1'b0};
	assign ioOeN = {2'b11, soOeN_ff, 1'b1};

	// crossings into clk
	always_ff @(posedge clk) begin
		if (!nrst) begin
			csS1_ff   <= 1'b1;
			csS2_ff   <= 1'b1;
			csPrev_ff <= 1'b1;
			frS1_ff   <= 1'b0;
			frS2_ff   <= 1'b0;
			dtS1_ff   <= 1'b0;
			dtS2_ff   <= 1'b0;
			dtPrev_ff <= 1'b0;
			rqS1_ff   <= 1'b0;
			rqS2_ff   <= 1'b0;
			rqPrev_ff <= 1'b0;
		end else begin
			csS1_ff   <= csN;
			csS2_ff   <= csS1_ff;
			csPrev_ff <= csS2_ff;
			frS1_ff   <= frameTgl_ff;
			frS2_ff   <= frS1_ff;
			dtS1_ff   <= dataTgl_ff;
			dtS2_ff   <= dtS1_ff;
			dtPrev_ff <= dtS2_ff;
			rqS1_ff   <= reqTgl_ff;
			rqS2_ff   <= rqS1_ff;
			rqPrev_ff <= rqS2_ff;
		end
	end

	assign frameEnd   = csS2_ff && !csPrev_ff;
	assign frameStart = !csS2_ff && csPrev_ff;
	assign frameNew   = frS2_ff != frSeen_ff; // a select pulse with no clock edge is no frame
	assign byteEvt    = dtS2_ff != dtPrev_ff;
	assign reqEvt     = rqS2_ff != rqPrev_ff;

	assign secSel    = sec_select(link_ff.addr);
	assign secOk     = secSel != 2'h0;
	assign secLocked = secOk && otpLockBits[secSel - 2'h1];
	assign pageProt  = is_protected(link_ff.addr, blockProtectBits);

	assign decide    = frameEnd && frameNew && state_ff == ST_IDLE;
	assign goWake    = sleeping_ff && link_ff.cmd == CMD_WAKE && link_ff.atCmdEnd;
	assign goSleep   = !sleeping_ff && link_ff.cmd == CMD_SLEEP && link_ff.atCmdEnd;
	assign goErase   = !sleeping_ff && link_ff.cmd == CMD_SEC_ERASE && link_ff.atAddrEnd &&
		writeEnableLatch && secOk && !secLocked;
	assign goSecProg = !sleeping_ff && link_ff.cmd == CMD_SEC_PROG && link_ff.atByteEnd &&
		writeEnableLatch && secOk && !secLocked;
	assign goMain    = !sleeping_ff && link_ff.atByteEnd && writeEnableLatch && !pageProt &&
		(link_ff.cmd == CMD_DUAL_PROG ||
		(link_ff.cmd == CMD_QUAD_PROG && quadEnableBit));

	always_ff @(posedge clk) begin
		if (!nrst) begin
			frSeen_ff <= 1'b0;
		end else if (frameEnd) begin
			frSeen_ff <= frS2_ff;
		end
	end

	// page buffer takes bytes only while idle, so a busy cycle keeps its data
	assign bufIdx = first_ff ? link_ff.addr[7:0] : wrPtr_ff;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			vld_ff   <= '0;
			wrPtr_ff <= 8'h00;
			first_ff <= 1'b1;
		end else if (frameStart && state_ff == ST_IDLE) begin
			vld_ff   <= '0;
			first_ff <= 1'b1;
		end else if (byteEvt && state_ff == ST_IDLE) begin
			vld_ff[bufIdx] <= 1'b1;
			wrPtr_ff       <= bufIdx + 8'h01;
			first_ff       <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (byteEvt && state_ff == ST_IDLE) begin
			pageBuf[bufIdx] <= dataByte_ff;
		end
	end

	// sequencer
	always_ff @(posedge clk) begin
		if (!nrst) begin
			state_ff    <= ST_IDLE;
			op_ff       <= OP_MAIN;
			idx_ff      <= 9'h000;
			tmr_ff      <= 32'h0000_0000;
			sel_ff      <= 2'h0;
			page_ff     <= 16'h0000;
			wip_ff      <= 1'b0;
			welClr_ff   <= 1'b0;
			sleeping_ff <= 1'b0;
		end else begin
			welClr_ff <= 1'b0;
			case (state_ff)
				ST_IDLE: begin
					if (decide) begin
						sel_ff  <= secSel - 2'h1;
						page_ff <= link_ff.addr[23:8];
						idx_ff  <= 9'h000;
						if (goWake) begin
							sleeping_ff <= 1'b0;
						end else if (goSleep) begin
							state_ff <= ST_SLEEPDLY;
							tmr_ff   <= 32'(SLEEP_ENTRY_CYC - 1);
						end else if (goErase || goSecProg || goMain) begin
							state_ff <= ST_SWEEP;
							wip_ff   <= 1'b1;
							op_ff    <= goErase ? OP_SECERASE : (goSecProg ? OP_SECPROG : OP_MAIN);
						end
					end
				end
				ST_SWEEP: begin
					idx_ff <= idx_ff + 9'h001;
					if (idx_ff == 9'(PAGE_BYTES - 1)) begin
						state_ff <= ST_WAIT;
						tmr_ff   <= (op_ff == OP_SECERASE) ? 32'(SECTOR_ERASE_CYCLES - 1)
							: 32'(PAGE_PROG_CYCLES - 1);
					end
				end
				ST_WAIT: begin
					tmr_ff <= tmr_ff - 32'h0000_0001;
					if (tmr_ff == 32'h0000_0000) begin
						state_ff  <= ST_IDLE;
						wip_ff    <= 1'b0;
						welClr_ff <= 1'b1;
					end
				end
				ST_SLEEPDLY: begin
					tmr_ff <= tmr_ff - 32'h0000_0001;
					if (tmr_ff == 32'h0000_0000) begin
						state_ff    <= ST_IDLE;
						sleeping_ff <= 1'b1;
					end
				end
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	// security registers are memory: no reset, erase gives them a known value
	always_ff @(posedge clk) begin
		if (state_ff == ST_SWEEP && op_ff == OP_SECERASE) begin
			secMem[{sel_ff, idx_ff[7:0]}] <= ERASED_BYTE;
		end else if (state_ff == ST_SWEEP && op_ff == OP_SECPROG && vld_ff[idx_ff[7:0]]) begin
			secMem[{sel_ff, idx_ff[7:0]}] <= pageBuf[idx_ff[7:0]];
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			rdData_ff <= 8'h00;
		end else if (reqEvt && secOk) begin
			rdData_ff <= secMem[{secSel - 2'h1, rdByte_ff}];
		end
	end

	// only bytes actually sent are written, the rest of the page is untouched
	always_ff @(posedge clk) begin
		if (!nrst) begin
			progWr_ff <= '0;
		end else begin
			progWr_ff.valid <= state_ff == ST_SWEEP && op_ff == OP_MAIN && vld_ff[idx_ff[7:0]];
			progWr_ff.addr  <= {page_ff, idx_ff[7:0]};
			progWr_ff.data  <= pageBuf[idx_ff[7:0]];
		end
	end

	assign progWr          = progWr_ff;
	assign writeInProgress = wip_ff;
	assign welClear        = welClr_ff;
	assign sleeping        = sleeping_ff;

	sequence seqSleepAsk;
		decide && goSleep;
	endsequence

	sequence seqSleepIn;
		state_ff == ST_SLEEPDLY ##(SLEEP_LAT - 1) state_ff == ST_SLEEPDLY ##1 sleeping_ff;
	endsequence

	AST_SLEEP_ENTRY: assert property (@(posedge clk) disable iff (!nrst)
		seqSleepAsk |=> seqSleepIn)
		else $error("deep power-down not entered after the entry delay");

	AST_SLEEP_IDLE_ONLY: assert property (@(posedge clk) disable iff (!nrst)
		$rose(state_ff == ST_SLEEPDLY) |-> $past(state_ff) == ST_IDLE && !$past(wip_ff))
		else $error("power-down started during a busy cycle");

	AST_SLEEP_IGNORE: assert property (@(posedge clk) disable iff (!nrst)
		(decide && sleeping_ff && link_ff.cmd != CMD_WAKE) |=> sleeping_ff && state_ff == ST_IDLE)
		else $error("command acted on while in deep power-down");

	AST_NO_LATCH: assert property (@(posedge clk) disable iff (!nrst)
		(decide && !writeEnableLatch) |=> !wip_ff)
		else $error("program or erase accepted without write enable latch");

	AST_QUAD_NEEDS_QE: assert property (@(posedge clk) disable iff (!nrst)
		(decide && link_ff.cmd == CMD_QUAD_PROG && !quadEnableBit) |=> state_ff == ST_IDLE)
		else $error("quad program accepted with quad enable clear");

	AST_LOCKED: assert property (@(posedge clk) disable iff (!nrst)
		(decide && secLocked && (link_ff.cmd == CMD_SEC_ERASE || link_ff.cmd == CMD_SEC_PROG))
		|=> !wip_ff)
		else $error("locked security register was modified");

	AST_PROTECTED: assert property (@(posedge clk) disable iff (!nrst)
		(decide && pageProt && link_ff.cmd == CMD_DUAL_PROG) |=> state_ff == ST_IDLE)
		else $error("protected page accepted for programming");

	AST_ERASE_BOUNDARY: assert property (@(posedge clk) disable iff (!nrst)
		(decide && link_ff.cmd == CMD_SEC_ERASE && !link_ff.atAddrEnd) |=> !wip_ff)
		else $error("erase ran without select rising after the address");

	AST_SWEEP_LEN: assert property (@(posedge clk) disable iff (!nrst)
		$rose(state_ff == ST_SWEEP) |-> ##255 state_ff == ST_SWEEP ##1 state_ff == ST_WAIT)
		else $error("page sweep length is not one page");

	AST_END_CLEARS: assert property (@(posedge clk) disable iff (!nrst)
		$fell(wip_ff) |-> welClear && state_ff == ST_IDLE)
		else $error("cycle end did not clear the write enable latch");

	AST_READ_BUSY: assert property (@(negedge sclk) disable iff (csN)
		!soOeN_ff |-> !wipS2_ff && link_ff.cmd == CMD_SEC_READ)
		else $error("security read driven while busy");
endmodule

// File: hw/fmi_pkg.sv
// package: command codes, timing, address fields and carrier types of the flash sequencer
package fmi_pkg;
	localparam logic [7:0] CMD_DUAL_PROG  = 8'ha2;
	localparam logic [7:0] CMD_QUAD_PROG  = 8'h32;
	localparam logic [7:0] CMD_SEC_ERASE  = 8'h44;
	localparam logic [7:0] CMD_SEC_PROG   = 8'h42;
	localparam logic [7:0] CMD_SEC_READ   = 8'h48;
	localparam logic [7:0] CMD_SLEEP      = 8'hb9;
	localparam logic [7:0] CMD_WAKE       = 8'hab;

	// serial clock edges counted from chip select falling
	localparam logic [5:0] CMD_END        = 6'h08;
	localparam logic [5:0] ADDR_END       = 6'h20;
	localparam logic [5:0] DUMMY_END      = 6'h28;

	// security register address fields
	localparam logic [7:0] SEC_HI_VAL     = 8'h00;
	localparam logic [3:0] SEC_MID_VAL    = 4'h0;
	localparam logic [3:0] SEC_SEL_MAX    = 4'h3;
	localparam int         PAGE_BYTES     = 256;
	localparam int         SEC_REGS       = 3;
	localparam logic [7:0] ERASED_BYTE    = 8'hff;

	localparam int CLK_PERIOD_NS          = 10;
	localparam int SLEEP_ENTRY_DELAY_NS   = 3000;
	localparam int SLEEP_ENTRY_CYC        = (SLEEP_ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SECTOR_ERASE_TIME_US   = 50000;
	localparam int SECTOR_ERASE_CYC       = (SECTOR_ERASE_TIME_US * 1000) / CLK_PERIOD_NS;
	localparam int PAGE_PROG_TIME_US      = 700;
	localparam int PAGE_PROG_CYC          = (PAGE_PROG_TIME_US * 1000) / CLK_PERIOD_NS;

	typedef enum logic [3:0] {
		ST_IDLE     = 4'h1,
		ST_SWEEP    = 4'h2,
		ST_WAIT     = 4'h4,
		ST_SLEEPDLY = 4'h8
	} fmi_state_t;

	typedef enum logic [2:0] {
		OP_MAIN     = 3'h1,
		OP_SECPROG  = 3'h2,
		OP_SECERASE = 3'h4
	} fmi_op_t;

	// write toward the main array
	typedef struct packed {
		logic        valid;
		logic [23:0] addr;
		logic [7:0]  data;
	} fmi_wr_t;

	// frame summary held by the link side after its last edge
	typedef struct packed {
		logic [7:0]  cmd;
		logic [23:0] addr;
		logic        atCmdEnd;
		logic        atAddrEnd;
		logic        atByteEnd;
	} fmi_link_t;
endpackage

// File: tb/fmi_host.sv
// host spi controller model: drives select, serial clock and io lines of the sequencer
`timescale 1ns/10ps
module fmi_host (
	output logic            sclk,
	output logic            csN,
	output logic      [3:0] ioIn,
	input  wire logic [3:0] ioOut,
	input  wire logic [3:0] ioOeN
);
	logic [3:0] hostIo = 4'h5;

	// io1 is the answer line; while the device drives it the wire follows the device
	assign ioIn = {hostIo[3:2], (ioOeN[1] ? hostIo[1] : ioOut[1]), hostIo[0]};

	// select starts low for one step so the device sees a rising select and clears its frame counters and output shifter
	initial begin
		sclk = 1'b0;
		csN  = 1'b0;
		#1;
		csN  = 1'b1;
	end

	task automatic open1();
		#3;
		csN = 1'b0;
		#40;
	endtask

	// lines change while the clock is low, the device samples on the rise
	task automatic edge1(input logic [3:0] v, output logic so);
		sclk   = 1'b0;
		hostIo = v;
		#40;
		so   = ioIn[1];
		sclk = 1'b1;
		#40;
	endtask

	// groups go msb first and the highest lane carries the group msb
	task automatic putByte(input logic [7:0] b, input int lanes);
		logic so;
		for (int i = 8 - lanes; i >= 0; i -= lanes)
			edge1(lanes == 4 ? b[i+:4] : lanes == 2 ? {2'b00, b[i+:2]} : {3'b000, b[i]}, so);
	endtask

	task automatic getByte(output logic [7:0] b);
		logic so;
		for (int i = 7; i >= 0; i--) begin
			edge1(~hostIo, so);
			b[i] = so;
		end
	endtask

	// released lines swing to the opposite level so stale data cannot pass for an answer
	task automatic close1();
		sclk = 1'b0;
		#40;
		csN    = 1'b1;
		hostIo = ~hostIo;
		#80;
	endtask
endmodule

// File: tb/fmi_seq_tb.sv
// self-checking bench for the flash command sequencer
`timescale 1ns/10ps
module fmi_seq_tb
	import fmi_pkg::*;
;
	localparam int ERASE_CYC = 400;
	localparam int PROG_CYC  = 20;
	logic        clk = 1'b0;
	logic        nrst;
	logic        writeEnableLatch = 1'b0;
	logic        quadEnableBit = 1'b0;
	logic [4:0]  blockProtectBits = 5'h00;
	logic [2:0]  otpLockBits = 3'h0;
	logic        drove = 1'b0;
	logic        sclk, csN, writeInProgress, welClear, sleeping;
	logic [3:0]  ioIn, ioOut, ioOeN;
	fmi_wr_t     progWr;
	logic [31:0] wrQ[$];
	logic [7:0]  noData[$];
	int          mismatches = 0;
	int          checked = 0;

	// erase kept long enough that a whole read frame fits inside it
	fmi_seq #(.SECTOR_ERASE_CYCLES(ERASE_CYC), .PAGE_PROG_CYCLES(PROG_CYC)) dut_u (
		.clk(clk), .nrst(nrst), .sclk(sclk), .csN(csN), .ioIn(ioIn), .ioOut(ioOut),
		.ioOeN(ioOeN), .writeEnableLatch(writeEnableLatch), .quadEnableBit(quadEnableBit),
		.blockProtectBits(blockProtectBits), .otpLockBits(otpLockBits),
		.writeInProgress(writeInProgress), .welClear(welClear), .sleeping(sleeping),
		.progWr(progWr)
	);
	fmi_host host_u (.sclk(sclk), .csN(csN), .ioIn(ioIn), .ioOut(ioOut), .ioOeN(ioOeN));

	always #5 clk = ~clk;

	always @(posedge clk) begin
		if (progWr.valid === 1'b1)
			wrQ.push_back({progWr.addr, progWr.data});
		if (ioOeN[1] === 1'b0)
			drove <= 1'b1;
	end

	task automatic tally_and_finish();
		$display("comparisons %0d, mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic cycles(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic waitFor(input logic sel, input logic lvl, input int bound);
		int n;
		n = 0;
		while ((sel ? sleeping : writeInProgress) !== lvl) begin
			cycles(1);
			n++;
			if (n > bound) begin
				check("waitLimit", n, bound);
				tally_and_finish();
			end
		end
	endtask

	task automatic setIn(input logic w, input logic q, input logic [4:0] bp, input logic [2:0] lk);
		@(posedge clk);
		writeEnableLatch <= w;
		quadEnableBit    <= q;
		blockProtectBits <= bp;
		otpLockBits      <= lk;
	endtask

	task automatic frame(input logic [7:0] cmd, input logic [23:0] addr, input int nAddr,
			input logic [7:0] dat[$], input int lanes);
		host_u.open1();
		host_u.putByte(cmd, 1);
		for (int i = 2; i >= 3 - nAddr; i--)
			host_u.putByte(addr[i*8+:8], 1);
		foreach (dat[k])
			host_u.putByte(dat[k], lanes);
	endtask

	// extra edges leave select rising off a byte boundary
	task automatic send(input logic [7:0] cmd, input logic [23:0] addr, input int nAddr,
			input logic [7:0] dat[$], input int lanes, input int extra);
		logic so;
		frame(cmd, addr, nAddr, dat, lanes);
		repeat (extra)
			host_u.edge1(4'h0, so);
		host_u.close1();
	endtask

	task automatic expectBusy(input logic ok, input int cyc);
		if (ok) begin
			waitFor(1'b0, 1'b1, 20);
			waitFor(1'b0, 1'b0, cyc + 300);
			check("welClear", welClear, 1'b1);
		end else begin
			cycles(40);
			check("writeInProgress", writeInProgress, 1'b0);
		end
	endtask

	task automatic runProg(input logic [7:0] cmd, input int lanes, input logic [23:0] addr,
			input logic [7:0] dat[$], input logic ok, input int extra);
		logic [7:0] img[256];
		bit         hit[256];
		int         j;
		wrQ.delete();
		foreach (dat[k]) begin
			img[(addr[7:0] + k) % 256] = dat[k];
			hit[(addr[7:0] + k) % 256] = 1'b1;
		end
		send(cmd, addr, 3, dat, lanes, extra);
		expectBusy(ok, PROG_CYC + 256);
		j = 0;
		for (int o = 0; o < 256; o++)
			if (ok && hit[o]) begin
				check("progWr", wrQ[j], {addr[23:8], o[7:0], img[o]});
				j++;
			end
		check("writeCount", wrQ.size(), j);
	endtask

	task automatic readSec(input logic [23:0] addr, input logic [7:0] exp[$], input logic act);
		logic [7:0] b;
		drove = 1'b0;
		frame(CMD_SEC_READ, addr, 3, noData, 1);
		host_u.putByte(8'h00, 1);
		foreach (exp[k]) begin
			host_u.getByte(b);
			check("readByte", b, exp[k]);
		end
		if (!act)
			host_u.getByte(b);
		host_u.close1();
		check("readDrive", drove, act);
	endtask

	task automatic tProg();
		logic [7:0] big[$];
		for (int k = 0; k < 258; k++)
			big.push_back(k == 256 ? 8'ha5 : k == 257 ? 8'h3c : k[7:0]);
		setIn(1'b0, 1'b1, 5'h00, 3'h0);
		runProg(CMD_DUAL_PROG, 2, 24'h0123fe, '{8'h5a, 8'hc3, 8'h96}, 1'b0, 0);
		setIn(1'b1, 1'b0, 5'h00, 3'h0);
		runProg(CMD_DUAL_PROG, 2, 24'h0123fe, '{8'h5a, 8'hc3, 8'h96}, 1'b1, 0);
		runProg(CMD_QUAD_PROG, 4, 24'h0123fe, '{8'h5a, 8'hc3}, 1'b0, 0);
		setIn(1'b1, 1'b1, 5'h00, 3'h0);
		runProg(CMD_QUAD_PROG, 4, 24'h045610, '{8'h1e, 8'hb7}, 1'b1, 0);
		runProg(CMD_DUAL_PROG, 2, 24'h012300, big, 1'b1, 0);
		runProg(CMD_DUAL_PROG, 2, 24'h012340, '{8'h77}, 1'b0, 2);
		setIn(1'b1, 1'b1, 5'h01, 3'h0);
		runProg(CMD_QUAD_PROG, 4, 24'h0f1200, '{8'h5a}, 1'b0, 0);
		runProg(CMD_DUAL_PROG, 2, 24'h0f12fe, '{8'h5a}, 1'b0, 0);
		runProg(CMD_DUAL_PROG, 2, 24'h0e1200, '{8'h69}, 1'b1, 0);
	endtask

	task automatic tSec();
		setIn(1'b1, 1'b0, 5'h00, 3'h0);
		send(CMD_SEC_ERASE, 24'h0010a7, 3, noData, 1, 0);
		waitFor(1'b0, 1'b1, 20);
		readSec(24'h001000, noData, 1'b0);
		expectBusy(1'b1, ERASE_CYC + 256);
		send(CMD_SEC_ERASE, 24'h001000, 3, noData, 1, 1);
		expectBusy(1'b0, 0);
		send(CMD_SEC_PROG, 24'h001000, 3, '{8'h81, 8'h7e}, 1, 0);
		expectBusy(1'b1, PROG_CYC + 256);
		readSec(24'h0010ff, '{8'hff, 8'h81, 8'h7e}, 1'b1);
		setIn(1'b1, 1'b0, 5'h00, 3'h1);
		send(CMD_SEC_PROG, 24'h001000, 3, '{8'h00}, 1, 0);
		expectBusy(1'b0, 0);
		send(CMD_SEC_ERASE, 24'h001000, 3, noData, 1, 0);
		expectBusy(1'b0, 0);
		readSec(24'h001000, '{8'h81}, 1'b1);
		send(CMD_SEC_PROG, 24'h002005, 3, '{8'h42}, 1, 0);
		expectBusy(1'b1, PROG_CYC + 256);
		readSec(24'h002005, '{8'h42}, 1'b1);
		readSec(24'h001100, noData, 1'b0);
		setIn(1'b0, 1'b0, 5'h00, 3'h0);
		send(CMD_SEC_PROG, 24'h002006, 3, '{8'h24}, 1, 0);
		expectBusy(1'b0, 0);
	endtask

	task automatic tSleep();
		setIn(1'b1, 1'b0, 5'h00, 3'h0);
		send(CMD_SLEEP, 24'h0, 0, noData, 1, 1);
		cycles(400);
		check("sleeping", sleeping, 1'b0);
		send(CMD_SLEEP, 24'h0, 0, noData, 1, 0);
		cycles(250);
		check("sleeping", sleeping, 1'b0);
		waitFor(1'b1, 1'b1, 100);
		send(CMD_SEC_ERASE, 24'h002000, 3, noData, 1, 0);
		expectBusy(1'b0, 0);
		readSec(24'h002005, noData, 1'b0);
		send(CMD_WAKE, 24'h0, 0, noData, 1, 0);
		waitFor(1'b1, 1'b0, 20);
		send(CMD_SEC_ERASE, 24'h002000, 3, noData, 1, 0);
		waitFor(1'b0, 1'b1, 20);
		send(CMD_SLEEP, 24'h0, 0, noData, 1, 0);
		expectBusy(1'b1, ERASE_CYC + 256);
		cycles(400);
		check("sleeping", sleeping, 1'b0);
	endtask

	// reset is entered on a clock edge so the link side sees a falling reset and clears
	initial begin
		@(posedge clk);
		nrst <= 1'b0;
		cycles(11);
		check("sleeping", sleeping, 1'b0);
		check("writeInProgress", writeInProgress, 1'b0);
		check("progWrValid", progWr.valid, 1'b0);
		check("ioOeN", ioOeN, 4'hf);
		@(posedge clk);
		nrst <= 1'b1;
		cycles(3);
		tProg();
		tSec();
		tSleep();
		tally_and_finish();
	end
endmodule
